// ==== clm_pkg.sv ====
// shared constants and types for the cache line management block
package clm_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int WAYS = 4;
   localparam int LOCK_WAYS = 2;
   localparam int LINE_W = 128;
   localparam int OFS_W = 4;
   localparam int WSEL_LSB = 2;
   localparam int D_LINES_DEF = 512;
   localparam int I_LINES_DEF = 1024;
   localparam logic [3:0] LINE_OFS0 = 4'h0;
   localparam logic [3:0] MASK_LINE = 4'hf;
   localparam logic [3:0] MASK_NONE = 4'h0;
   localparam logic [3:0] MASK_W0 = 4'h1;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTL = 8'h00;
   localparam logic [7:0] OFF_PUSH = 8'h04;
   localparam logic [7:0] OFF_REG0 = 8'h08;
   localparam logic [7:0] OFF_REG1 = 8'h0c;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam int CTL_DEN = 31;
   localparam int CTL_DPK = 28;
   localparam int CTL_DLOCK = 27;
   localparam int CTL_DDM = 25;
   localparam int CTL_DINV = 24;
   localparam int CTL_IEN = 15;
   localparam int CTL_IPK = 12;
   localparam int CTL_IINV = 8;
   localparam logic [31:0] CTL_RST = 32'h0000_0000;
   localparam logic [31:0] CTL_STORE = 32'h9a00_9000;
   localparam int PUSH_ISEL = 31;
   localparam int PUSH_WAY_LSB = 0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int HPROT_PRIV = 1;
   localparam logic HRESP_OKAY = 1'b0;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_FILL, ST_VICW, ST_WORD, ST_PUSH} clm_state_t;
   typedef struct packed {
      logic [7:0] base;
      logic [7:0] mask;
      logic en;
      logic [13:0] rsvd;
      logic copyback;
   } clm_region_t;
   typedef struct packed {
      logic valid;
      logic instr;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } clm_core_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } clm_core_rsp_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] wmask;
      logic [31:0] addr;
      logic [LINE_W-1:0] wline;
   } clm_mem_req_t;
   typedef struct packed {
      logic ack;
      logic [LINE_W-1:0] rline;
   } clm_mem_rsp_t;
endpackage

// ==== clm_cache_ctrl.sv ====
// split cache controller with line push, fills and victim copyback
`timescale 1ns/100ps
// Summary of operation
// - reset clears control register, caches off
// - reset leaves tags, states, data untouched
// - line push allowed only when privileged
// - push index selects set and way
// - push keep-valid bit chooses invalidate
// - push and invalidate ignore enable bits
// - disabled cache: no lookup, contents kept
// - four ways per set
// - 512 data lines, 1024 instruction lines
// - instruction cache read only, valid/invalid
// - data line has valid and modified flags
// - region mode else default data mode
// - copyback read or write miss fills line
// - fill uses invalid way first, sets valid
// - full set: round robin victim
// - dirty victim written after fill completes
// - write-through never marks lines modified
// - lock stops allocation in ways 0,1
// - victim buffer holds one 16-byte line
module clm_cache_ctrl #(
   parameter int D_LINES = clm_pkg::D_LINES_DEF,
   parameter int I_LINES = clm_pkg::I_LINES_DEF
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire clm_pkg::clm_core_req_t core_req,
   output logic core_ready,
   output clm_pkg::clm_core_rsp_t core_rsp,
   output clm_pkg::clm_mem_req_t mem_req,
   input wire clm_pkg::clm_mem_rsp_t mem_rsp
);
   localparam int W = clm_pkg::WAYS;
   localparam int LW = clm_pkg::LINE_W;
   localparam int OW = clm_pkg::OFS_W;
   localparam int D_SETS = D_LINES / W;
   localparam int I_SETS = I_LINES / W;
   localparam int D_IW = $clog2(D_SETS);
   localparam int I_IW = $clog2(I_SETS);
   localparam int D_TW = 32 - OW - D_IW;
   localparam int I_TW = 32 - OW - I_IW;

   if (D_SETS < 2 || I_SETS < 2 || (1 << D_IW) != D_SETS || (1 << I_IW) != I_SETS
       || D_LINES % W != 0 || I_LINES % W != 0)
   begin : g_chk
      $error("line counts must be four ways times a power of two sets");
   end

   // ----------------------------------------------------------------
   // arrays and state
   // ----------------------------------------------------------------
   logic [D_TW-1:0] d_tag [W][D_SETS];
   logic [LW-1:0] d_data [W][D_SETS];
   logic [D_SETS-1:0] d_valid [W];
   logic [D_SETS-1:0] d_mod [W];
   logic [I_TW-1:0] i_tag [W][I_SETS];
   logic [LW-1:0] i_data [W][I_SETS];
   logic [I_SETS-1:0] i_valid [W];

   logic [31:0] ctl_r;
   logic [31:0] push_idx_r;
   logic push_pend_r;
   clm_pkg::clm_region_t reg0_r;
   clm_pkg::clm_region_t reg1_r;
   clm_pkg::clm_state_t state_r;
   logic f_instr_r, f_alloc_r, f_wr_r, f_cb_r;
   logic [1:0] f_way_r;
   logic [31:0] f_addr_r;
   logic [31:0] f_wdata_r;
   logic [LW-1:0] vbuf_r;
   logic [31:0] vaddr_r;
   logic vbuf_v_r;
   logic [1:0] d_rr_r, i_rr_r;
   clm_pkg::clm_mem_req_t mreq_r;
   clm_pkg::clm_core_rsp_t rsp_r;
   logic [31:0] hrdata_r;
   logic a_act_r, a_wr_r, a_ok_r, a_priv_r;
   logic [7:0] a_addr_r;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [LW-1:0] put_word(input logic [LW-1:0] line,
                                              input logic [1:0] sel, input logic [31:0] w);
      logic [LW-1:0] r;
      r = line;
      r[sel*32 +: 32] = w;
      return r;
   endfunction

   // {found, way}: lowest invalid way that may be allocated
   function automatic logic [2:0] pick_free(input logic [3:0] v, input logic lock);
      logic [2:0] r;
      r = 3'h0;
      for (int w = W - 1; w >= 0; w--)
         if (!v[w] && !(lock && w < clm_pkg::LOCK_WAYS))
            r = {1'b1, 2'(w)};
      return r;
   endfunction

   function automatic logic [1:0] enc4(input logic [3:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int w = 0; w < W; w++)
         if (v[w])
            r = 2'(w);
      return r;
   endfunction

   function automatic logic region_hit(input clm_pkg::clm_region_t g, input logic [31:0] a);
      return g.en && (((a[31:24] ^ g.base) & ~g.mask) == 8'h00);
   endfunction

   // ----------------------------------------------------------------
   // core lookup
   // ----------------------------------------------------------------
   wire [31:0] c_addr = core_req.addr;
   wire [D_IW-1:0] c_dset = c_addr[OW +: D_IW];
   wire [I_IW-1:0] c_iset = c_addr[OW +: I_IW];
   wire [D_TW-1:0] c_dtag = c_addr[31 -: D_TW];
   wire [I_TW-1:0] c_itag = c_addr[31 -: I_TW];
   wire [1:0] c_wsel = c_addr[clm_pkg::WSEL_LSB +: 2];
   logic [3:0] d_hitv, i_hitv, d_vld4, i_vld4, d_mod4;

   for (genvar w = 0; w < W; w++)
   begin : g_way
      assign d_vld4[w] = d_valid[w][c_dset];
      assign d_mod4[w] = d_mod[w][c_dset];
      assign i_vld4[w] = i_valid[w][c_iset];
      assign d_hitv[w] = d_vld4[w] && d_tag[w][c_dset] == c_dtag;
      assign i_hitv[w] = i_vld4[w] && i_tag[w][c_iset] == c_itag;
   end

   wire c_instr = core_req.instr;
   wire c_wr = core_req.write & ~c_instr;
   wire dlock = ctl_r[clm_pkg::CTL_DLOCK];
   wire c_en = c_instr ? ctl_r[clm_pkg::CTL_IEN] : ctl_r[clm_pkg::CTL_DEN];
   wire [3:0] c_hitv = c_instr ? i_hitv : d_hitv;
   wire c_hit = c_en & (|c_hitv);
   wire [1:0] c_way = enc4(c_hitv);
   wire c_cb = region_hit(reg0_r, c_addr) ? reg0_r.copyback :
               region_hit(reg1_r, c_addr) ? reg1_r.copyback :
               ctl_r[clm_pkg::CTL_DDM];
   wire c_alloc = c_en & ~c_hit & (~c_wr | c_cb);
   wire [2:0] c_free = c_instr ? pick_free(i_vld4, 1'b0) : pick_free(d_vld4, dlock);
   wire [1:0] rr_way = c_instr ? i_rr_r : (dlock ? {1'b1, d_rr_r[0]} : d_rr_r);
   wire [1:0] c_vway = c_free[2] ? c_free[1:0] : rr_way;
   wire c_vic_dirty = ~c_instr & c_alloc & ~c_free[2] & d_mod4[c_vway];
   wire [LW-1:0] c_line = c_instr ? i_data[c_way][c_iset] : d_data[c_way][c_dset];
   wire [31:0] c_word = c_line[c_wsel*32 +: 32];

   wire st_idle = state_r == clm_pkg::ST_IDLE;
   wire take = core_req.valid & core_ready;
   wire hit_wr = take & c_hit & c_wr;

   // ----------------------------------------------------------------
   // line push decode
   // ----------------------------------------------------------------
   wire p_instr = push_idx_r[clm_pkg::PUSH_ISEL];
   wire [D_IW-1:0] p_dset = push_idx_r[OW +: D_IW];
   wire [I_IW-1:0] p_iset = push_idx_r[OW +: I_IW];
   wire [1:0] p_way = push_idx_r[clm_pkg::PUSH_WAY_LSB +: 2];
   wire p_dirty = ~p_instr & d_valid[p_way][p_dset] & d_mod[p_way][p_dset];
   wire p_keep = p_instr ? ctl_r[clm_pkg::CTL_IPK] : ctl_r[clm_pkg::CTL_DPK];
   wire take_push = ce & st_idle & push_pend_r;
   wire m_ack = mem_rsp.ack & mreq_r.valid;
   wire p_clr = (take_push & ~p_dirty) | (state_r == clm_pkg::ST_PUSH & m_ack);

   wire fill_done = state_r == clm_pkg::ST_FILL & m_ack;
   wire fill_wr = fill_done & f_alloc_r;
   wire [D_IW-1:0] f_dset = f_addr_r[OW +: D_IW];
   wire [I_IW-1:0] f_iset = f_addr_r[OW +: I_IW];
   wire [1:0] f_wsel = f_addr_r[clm_pkg::WSEL_LSB +: 2];

   // ----------------------------------------------------------------
   // register bus decode
   // ----------------------------------------------------------------
   wire a_take = hready & hsel & htrans[1];
   wire wr_go = a_act_r & a_wr_r & a_ok_r;
   wire wr_ctl = wr_go & a_addr_r == clm_pkg::OFF_CTL;
   wire wr_push = wr_go & a_addr_r == clm_pkg::OFF_PUSH;
   wire wr_reg0 = wr_go & a_addr_r == clm_pkg::OFF_REG0;
   wire wr_reg1 = wr_go & a_addr_r == clm_pkg::OFF_REG1;
   wire inv_d = wr_ctl & hwdata[clm_pkg::CTL_DINV];
   wire inv_i = wr_ctl & hwdata[clm_pkg::CTL_IINV];
   wire [31:0] stat = {29'h0, vbuf_v_r, ~st_idle, push_pend_r};
   wire [7:0] ra = haddr[7:0];
   wire [31:0] rd_val = ra == clm_pkg::OFF_CTL ? ctl_r :
                        ra == clm_pkg::OFF_PUSH ? push_idx_r :
                        ra == clm_pkg::OFF_REG0 ? reg0_r :
                        ra == clm_pkg::OFF_REG1 ? reg1_r :
                        ra == clm_pkg::OFF_STAT ? stat : 32'h0;

   assign hreadyout = ce;
   assign hrdata = hrdata_r;
   assign hresp = clm_pkg::HRESP_OKAY;
   assign core_ready = ce & st_idle & ~push_pend_r;
   assign core_rsp = rsp_r;
   assign mem_req = mreq_r;

   // ----------------------------------------------------------------
   // cache arrays, never reset
   // ----------------------------------------------------------------
   always_ff @(posedge hclk)
   begin
      if (ce)
      begin
         // invalidate first so a fill landing in the same cycle survives
         for (int w = 0; w < W; w++)
         begin
            if (inv_d)
               d_valid[w] <= '0;
            if (inv_i)
               i_valid[w] <= '0;
         end
         if (fill_wr && f_instr_r)
         begin
            i_tag[f_way_r][f_iset] <= f_addr_r[31 -: I_TW];
            i_data[f_way_r][f_iset] <= mem_rsp.rline;
            i_valid[f_way_r][f_iset] <= 1'b1;
         end
         if (fill_wr && !f_instr_r)
         begin
            d_tag[f_way_r][f_dset] <= f_addr_r[31 -: D_TW];
            d_data[f_way_r][f_dset] <= f_wr_r ? put_word(mem_rsp.rline, f_wsel, f_wdata_r)
                                                : mem_rsp.rline;
            d_valid[f_way_r][f_dset] <= 1'b1;
            d_mod[f_way_r][f_dset] <= f_wr_r & f_cb_r;
         end
         if (hit_wr)
         begin
            d_data[c_way][c_dset] <= put_word(c_line, c_wsel, core_req.wdata);
            if (c_cb)
               d_mod[c_way][c_dset] <= 1'b1;
         end
         if (p_clr && p_instr && !p_keep)
            i_valid[p_way][p_iset] <= 1'b0;
         if (p_clr && !p_instr)
         begin
            d_mod[p_way][p_dset] <= 1'b0;
            if (!p_keep)
               d_valid[p_way][p_dset] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers and sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctl_r <= clm_pkg::CTL_RST;
         push_idx_r <= '0;
         push_pend_r <= 1'b0;
         reg0_r <= '0;
         reg1_r <= '0;
         state_r <= clm_pkg::ST_IDLE;
         f_instr_r <= 1'b0;
         f_alloc_r <= 1'b0;
         f_wr_r <= 1'b0;
         f_cb_r <= 1'b0;
         f_way_r <= '0;
         f_addr_r <= '0;
         f_wdata_r <= '0;
         vbuf_r <= '0;
         vaddr_r <= '0;
         vbuf_v_r <= 1'b0;
         d_rr_r <= '0;
         i_rr_r <= '0;
         mreq_r <= '0;
         rsp_r <= '0;
         hrdata_r <= '0;
         a_act_r <= 1'b0;
         a_wr_r <= 1'b0;
         a_ok_r <= 1'b0;
         a_priv_r <= 1'b0;
         a_addr_r <= '0;
      end
      else if (ce)
      begin
         if (hready)
         begin
            a_act_r <= a_take;
            a_wr_r <= hwrite;
            a_ok_r <= hsize == clm_pkg::HSIZE_WORD;
            a_priv_r <= hprot[clm_pkg::HPROT_PRIV];
            a_addr_r <= haddr[7:0];
         end
         if (a_take && !hwrite)
            hrdata_r <= rd_val;
         if (wr_ctl)
            ctl_r <= hwdata & clm_pkg::CTL_STORE;
         if (wr_reg0)
            reg0_r <= hwdata;
         if (wr_reg1)
            reg1_r <= hwdata;
         if (wr_push && a_priv_r && !push_pend_r)
         begin
            push_idx_r <= hwdata;
            push_pend_r <= 1'b1;
         end
         rsp_r.ack <= 1'b0;
         unique case (state_r)
            clm_pkg::ST_IDLE:
            begin
               if (take_push)
               begin
                  push_pend_r <= 1'b0;
                  if (p_dirty)
                  begin
                     mreq_r <= {1'b1, 1'b1, clm_pkg::MASK_LINE,
                                d_tag[p_way][p_dset], p_dset, clm_pkg::LINE_OFS0,
                                d_data[p_way][p_dset]};
                     state_r <= clm_pkg::ST_PUSH;
                  end
               end
               else if (take && c_hit && (!c_wr || c_cb))
               begin
                  rsp_r <= {1'b1, c_word};
               end
               else if (take && !c_alloc)
               begin
                  // uncached or write-through: single word out, or line read
                  mreq_r <= {1'b1, c_wr, c_wr ? clm_pkg::MASK_W0 << c_wsel : clm_pkg::MASK_NONE,
                             c_addr, {4{core_req.wdata}}};
                  f_alloc_r <= 1'b0;
                  f_addr_r <= c_addr;
                  state_r <= c_wr ? clm_pkg::ST_WORD : clm_pkg::ST_FILL;
               end
               else if (take)
               begin
                  mreq_r <= {1'b1, 1'b0, clm_pkg::MASK_NONE, c_addr[31:OW], clm_pkg::LINE_OFS0,
                             {LW{1'b0}}};
                  f_alloc_r <= 1'b1;
                  f_instr_r <= c_instr;
                  f_wr_r <= c_wr;
                  f_cb_r <= c_cb;
                  f_way_r <= c_vway;
                  f_addr_r <= c_addr;
                  f_wdata_r <= core_req.wdata;
                  state_r <= clm_pkg::ST_FILL;
                  if (c_vic_dirty)
                  begin
                     vbuf_r <= d_data[c_vway][c_dset];
                     vaddr_r <= {d_tag[c_vway][c_dset], c_dset, clm_pkg::LINE_OFS0};
                     vbuf_v_r <= 1'b1;
                  end
                  if (!c_free[2] && c_instr)
                     i_rr_r <= i_rr_r + 2'h1;
                  if (!c_free[2] && !c_instr)
                     d_rr_r <= d_rr_r + 2'h1;
               end
            end
            clm_pkg::ST_FILL:
            begin
               if (m_ack)
               begin
                  rsp_r <= {1'b1, mem_rsp.rline[f_wsel*32 +: 32]};
                  if (vbuf_v_r)
                  begin
                     mreq_r <= {1'b1, 1'b1, clm_pkg::MASK_LINE, vaddr_r, vbuf_r};
                     state_r <= clm_pkg::ST_VICW;
                  end
                  else
                  begin
                     mreq_r.valid <= 1'b0;
                     state_r <= clm_pkg::ST_IDLE;
                  end
               end
            end
            clm_pkg::ST_VICW:
            begin
               if (m_ack)
               begin
                  vbuf_v_r <= 1'b0;
                  mreq_r.valid <= 1'b0;
                  state_r <= clm_pkg::ST_IDLE;
               end
            end
            clm_pkg::ST_WORD:
            begin
               if (m_ack)
               begin
                  rsp_r <= {1'b1, 32'h0};
                  mreq_r.valid <= 1'b0;
                  state_r <= clm_pkg::ST_IDLE;
               end
            end
            clm_pkg::ST_PUSH:
            begin
               if (m_ack)
               begin
                  mreq_r.valid <= 1'b0;
                  state_r <= clm_pkg::ST_IDLE;
               end
            end
            default:
            begin
               state_r <= clm_pkg::ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== clm_cache_ctrl_checker.sv ====
// port assertions for the cache controller
`timescale 1ns/100ps
module clm_cache_ctrl_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire clm_pkg::clm_core_req_t core_req,
   input wire logic core_ready,
   input wire clm_pkg::clm_core_rsp_t core_rsp,
   input wire clm_pkg::clm_mem_req_t mem_req,
   input wire clm_pkg::clm_mem_rsp_t mem_rsp
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   hresp_okay_a: assert property (hresp == clm_pkg::HRESP_OKAY)
      else $error("hresp not okay");
   ready_ce_a: assert property (hreadyout == ce)
      else $error("hreadyout differs from ce");
   rst_quiet_a: assert property ($rose(hresetn) |-> !mem_req.valid && !core_rsp.ack)
      else $error("activity right after reset");
   ack_once_a: assert property (core_rsp.ack && ce && !core_req.valid |=> !core_rsp.ack)
      else $error("ack longer than one cycle");
   mem_hold_a: assert property (mem_req.valid && !mem_rsp.ack && ce |=>
      mem_req.valid && $stable(mem_req.addr) && $stable(mem_req.write))
      else $error("memory request dropped before ack");
   word_wr_a: assert property (mem_req.valid && mem_req.write &&
      mem_req.wmask != clm_pkg::MASK_LINE |->
      $onehot(mem_req.wmask) && mem_req.wline[31:0] == mem_req.wline[127:96])
      else $error("bad word write");
   line_wr_a: assert property (mem_req.valid && mem_req.wmask == clm_pkg::MASK_LINE |->
      mem_req.write && mem_req.addr[3:0] == clm_pkg::LINE_OFS0)
      else $error("line write not aligned");
   ack_no_fill_a: assert property (core_rsp.ack |-> !(mem_req.valid && !mem_req.write))
      else $error("ack while line read pending");
   busy_ready_a: assert property (mem_req.valid |-> !core_ready)
      else $error("core ready while memory busy");
   freeze_a: assert property (!ce |=> $stable(mem_req) && $stable(core_rsp))
      else $error("state moved with ce low");
   line_wr_c: cover property (mem_req.valid && mem_req.wmask == clm_pkg::MASK_LINE);
   word_wr_c: cover property (mem_req.valid && mem_req.wmask == clm_pkg::MASK_W0);
   ack_c: cover property (core_rsp.ack);
endmodule
bind clm_cache_ctrl clm_cache_ctrl_checker u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hprot(hprot), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .core_req(core_req), .core_ready(core_ready),
   .core_rsp(core_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp));

// ==== clm_mem_model.sv ====
// behavioural line memory on the far side of the controller
`timescale 1ns/100ps
module clm_mem_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] dly,
   input wire clm_pkg::clm_mem_req_t mem_req,
   output clm_pkg::clm_mem_rsp_t mem_rsp,
   output int m_rd,
   output int m_wr,
   output logic m_lastw,
   output logic [31:0] m_wa,
   output logic [127:0] m_wl
);
   logic [127:0] mem [logic [27:0]];
   logic [127:0] ln;
   int cnt;
   wire logic [27:0] la = mem_req.addr[31:4];
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mem_rsp <= '0;
         cnt <= 0;
         m_rd <= 0;
         m_wr <= 0;
      end
      else if (mem_req.valid && !mem_rsp.ack && cnt >= int'(dly))
      begin
         ln = mem.exists(la) ? mem[la] : {4{4'h0, la}};
         for (int i = 0; i < 4; i++)
            if (mem_req.wmask[i])
               ln[32*i +: 32] = mem_req.wline[32*i +: 32];
         if (mem_req.write)
         begin
            mem[la] = ln;
            m_wr <= m_wr + 1;
            m_wa <= mem_req.addr;
            m_wl <= mem_req.wline;
         end
         else
            m_rd <= m_rd + 1;
         m_lastw <= mem_req.write;
         mem_rsp <= '{1'b1, mem_req.write ? ~mem_rsp.rline : ln};
         cnt <= 0;
      end
      else
      begin
         // data lines toggle while no line is returned
         cnt <= (mem_req.valid && !mem_rsp.ack) ? cnt + 1 : 0;
         mem_rsp <= '{1'b0, ~mem_rsp.rline};
      end
   end
endmodule

// ==== cache_line_management_tb.sv ====
// self-checking bench for the cache line management block
`timescale 1ns/100ps
module cache_line_management_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [3:0] hprot = 4'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] dly = 4'h0;
   clm_pkg::clm_core_req_t creq = '0;
   logic hreadyout, hresp, core_ready, m_lastw;
   logic [31:0] hrdata, m_wa, rd;
   logic [127:0] m_wl;
   clm_pkg::clm_core_rsp_t core_rsp;
   clm_pkg::clm_mem_req_t mem_req;
   clm_pkg::clm_mem_rsp_t mem_rsp;
   int m_rd, m_wr, r0, w0;
   int error_cnt = 0;
   int n_checks = 0;
   always #2 hclk = ~hclk;
   clm_cache_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(clm_pkg::HSIZE_WORD), .hprot(hprot),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .core_req(creq), .core_ready(core_ready), .core_rsp(core_rsp),
      .mem_req(mem_req), .mem_rsp(mem_rsp));
   clm_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .dly(dly), .mem_req(mem_req),
      .mem_rsp(mem_rsp), .m_rd(m_rd), .m_wr(m_wr), .m_lastw(m_lastw), .m_wa(m_wa),
      .m_wl(m_wl));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] ad(input int k);
      return 32'h100 + 32'(k) * 32'h800;
   endfunction
   function automatic logic [31:0] dflt(input logic [31:0] a);
      return {4'h0, a[31:4]};
   endfunction
   function automatic logic [31:0] wd(input int k);
      return 32'hd000_0000 | 32'(k);
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("FAIL %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic report_and_stop;
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic ahb(input logic w, p, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hprot <= {2'h0, p, 1'b1};
      do
         @(negedge hclk);
      while (hreadyout !== 1'b1);
      @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      do
         @(negedge hclk);
      while (hreadyout !== 1'b1);
      @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic ctl(input logic [31:0] v);
      ahb(1'b1, 1'b1, 32'(clm_pkg::OFF_CTL), v);
   endtask
   task automatic core(input logic i, w, input logic [31:0] a, d);
      @(posedge hclk);
      creq <= '{1'b1, i, w, a, d};
      do
         @(negedge hclk);
      while (core_ready !== 1'b1);
      @(posedge hclk);
      creq.valid <= 1'b0;
      do
         @(negedge hclk);
      while (core_rsp.ack !== 1'b1);
      rd = core_rsp.rdata;
      // wait out any victim writeback
      do
         @(negedge hclk);
      while (core_ready !== 1'b1);
   endtask
   task automatic mem_ops(input int dr, dw);
      chk("mem reads", 32'(m_rd - r0), 32'(dr));
      chk("mem writes", 32'(m_wr - w0), 32'(dw));
      r0 = m_rd;
      w0 = m_wr;
   endtask
   task automatic push(input logic p, input logic [31:0] v);
      ahb(1'b1, p, 32'(clm_pkg::OFF_PUSH), v);
      do
         ahb(1'b0, 1'b1, 32'(clm_pkg::OFF_STAT), 32'h0);
      while (rd[1:0] !== 2'h0);
   endtask
   task automatic pushset(input logic [31:0] a);
      for (int w = 0; w < 4; w++)
         push(1'b1, (a & 32'h7f0) | 32'(w));
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      int k;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, 1'b1, 32'(clm_pkg::OFF_CTL), 32'h0);
      chk("ctl reset", rd, clm_pkg::CTL_RST);
      ahb(1'b0, 1'b1, 32'h14, 32'h0);
      chk("unmapped", rd, 32'h0);
      ctl(32'h8300_8100);
      ahb(1'b0, 1'b1, 32'(clm_pkg::OFF_CTL), 32'h0);
      chk("ctl", rd, 32'h8300_8100 & clm_pkg::CTL_STORE);
      r0 = m_rd;
      w0 = m_wr;
      core(1'b0, 1'b0, ad(0), 32'h0);
      chk("miss data", rd, dflt(ad(0)));
      core(1'b0, 1'b1, ad(0), wd(0));
      core(1'b0, 1'b0, ad(0), 32'h0);
      chk("hit data", rd, wd(0));
      mem_ops(1, 0);
      for (k = 1; k < 4; k++)
         core(1'b0, 1'b1, ad(k), wd(k));
      mem_ops(3, 0);
      dly <= 4'h3;
      core(1'b0, 1'b0, ad(4), 32'h0);
      mem_ops(1, 1);
      chk("victim last", 32'(m_lastw), 32'h1);
      chk("victim addr", m_wa, ad(0));
      chk("victim w0", m_wl[31:0], wd(0));
      chk("victim w1", m_wl[63:32], dflt(ad(0)));
      dly <= 4'h0;
      push(1'b0, ad(0) & 32'h7f0);
      ahb(1'b0, 1'b1, 32'(clm_pkg::OFF_PUSH), 32'h0);
      chk("push priv", rd, 32'h0);
      mem_ops(0, 0);
      pushset(ad(0));
      mem_ops(0, 3);
      core(1'b0, 1'b0, ad(4), 32'h0);
      mem_ops(1, 0);
      ctl(32'h9200_8000);
      core(1'b0, 1'b1, ad(4), wd(4));
      pushset(ad(0));
      mem_ops(0, 1);
      core(1'b0, 1'b0, ad(4), 32'h0);
      chk("kept", rd, wd(4));
      pushset(ad(0));
      mem_ops(0, 0);
      ctl(32'h1200_8000);
      core(1'b0, 1'b0, ad(4), 32'h0);
      chk("uncached", rd, wd(4));
      mem_ops(1, 0);
      ctl(32'h9200_8000);
      core(1'b0, 1'b0, ad(4), 32'h0);
      mem_ops(0, 0);
      ctl(32'h8a00_8000);
      core(1'b0, 1'b0, ad(5), 32'h0);
      push(1'b1, (ad(0) & 32'h7f0) | 32'h1);
      core(1'b0, 1'b0, ad(5), 32'h0);
      mem_ops(1, 0);
      ahb(1'b1, 1'b1, 32'(clm_pkg::OFF_REG0), 32'h0000_8000);
      core(1'b0, 1'b1, ad(4), wd(5));
      pushset(ad(0));
      mem_ops(0, 1);
      core(1'b1, 1'b0, 32'h0001_0000, 32'h0);
      core(1'b1, 1'b1, 32'h0001_0000, wd(7));
      chk("fetch", rd, dflt(32'h0001_0000));
      mem_ops(1, 0);
      @(posedge hclk);
      ce <= 1'b0;
      repeat (2) @(posedge hclk);
      ce <= 1'b1;
      report_and_stop();
   end
   initial
   begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
endmodule
